// file: hdl/fpec_defs.svh
// register offsets, field positions and reset values of the flash program/erase control
// assumes a 32-bit classic wishbone slave with one aligned word per register
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH

// byte offsets of the registers
`define FPEC_OFS_MODE_CONTROL 8'h00
`define FPEC_OFS_ERROR_STATUS 8'h04
`define FPEC_OFS_BLOCK_LOW 8'h08
`define FPEC_OFS_BLOCK_HIGH 8'h0c
`define FPEC_OFS_RAM_OVERLAY 8'h10

// decoded address width
`define FPEC_ADR_BITS 8

// mode control fields
`define FPEC_BIT_HW_WRITE_ENABLE 7
`define FPEC_BIT_SOFT_WRITE_ENABLE 6
`define FPEC_BIT_ERASE_SETUP 5
`define FPEC_BIT_PROGRAM_SETUP 4
`define FPEC_BIT_ERASE_VERIFY 3
`define FPEC_BIT_PROGRAM_VERIFY 2
`define FPEC_BIT_ERASE_RUN 1
`define FPEC_BIT_PROGRAM_RUN 0

// error status fields
`define FPEC_BIT_ERROR_PROTECT 7

// erase block select widths
`define FPEC_BLOCK_LOW_BITS 8
`define FPEC_BLOCK_HIGH_BITS 4
`define FPEC_BLOCK_BITS 12

// ram overlay control fields
`define FPEC_BIT_RAM_SELECT 3
`define FPEC_RAM_AREA_MSB 2

// reset values
`define FPEC_RST_MODE 6'h00
`define FPEC_RST_BLOCKS 12'h000
`define FPEC_RST_RAM 4'h0
`define FPEC_RST_PIN 1'b1

`endif

// file: hdl/fpec_pkg.sv
// types shared by the flash program/erase control files
// assumes fpec_defs.svh is compiled alongside
package fpec_pkg;

    // flash state as seen by the array; gray steps along setup, run, verify
    typedef enum logic [2:0] {
        FPEC_IDLE = 3'b000,
        FPEC_PROG_SETUP = 3'b001,
        FPEC_PROGRAM = 3'b011,
        FPEC_PROG_VERIFY = 3'b010,
        FPEC_ERASE_SETUP = 3'b110,
        FPEC_ERASE = 3'b111,
        FPEC_ERASE_VERIFY = 3'b101,
        FPEC_LOCKED = 3'b100
    } fpec_state_type;

endpackage

// file: hdl/fpec_sync.sv
// two flip-flop level synchroniser
// assumes the input is asynchronous to clk_i and changes slowly
module fpec_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // level in and out
    input wire logic async_i,
    output logic sync_o
);

    logic meta;
    logic next_meta;
    logic next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= RESET_VALUE;
            sync_o <= RESET_VALUE;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end

endmodule

// file: hdl/fpec_top.sv
// flash program/erase control registers behind a classic wishbone slave
// assumes the error-protection detector and the array sequencer sit on ref_clk_i
//
// Summary of operation
// - mode control bit 7 reads 1 while the write protect pin is low.
// - programming and erasing enabled only with soft enable written 1 and hardware flag 1.
// - with soft enable 0, no other mode bit nor block bit can be set.
// - erase setup bit 5 written 1 with both enables enters erase setup.
// - program setup bit 4 written 1 with both enables enters program setup.
// - erase verify bit 3 written 1 with both enables enters erase verify.
// - program verify bit 2 written 1 with both enables enters program verify.
// - erase run bit 1 starts erase only with both enables and erase setup.
// - program run bit 0 starts program only with both enables and program setup.
// - clearing a setup, verify or run bit cancels that state or mode.
// - entering error protection during program or erase sets status bit 7.
// - status bits 6 to 0 are reserved and read as zero.
// - both erase block registers stay zero while soft enable is zero.
// - more than one block bit set across both registers clears them all.
// - ram overlay select set protects all blocks against program and erase.

`include "fpec_defs.svh"

module fpec_top
    import fpec_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic write_protect_pin_i,
    // error protection detector
    input wire logic error_event_i,
    // flash array controls
    output logic erase_setup_o,
    output logic program_setup_o,
    output logic erase_verify_o,
    output logic program_verify_o,
    output logic erase_run_o,
    output logic program_run_o,
    output logic [`FPEC_BLOCK_BITS-1:0] erase_block_o,
    output logic ram_overlay_select_o,
    output logic [`FPEC_RAM_AREA_MSB:0] ram_area_o,
    output logic error_protect_flag_o,
    output fpec_state_type flash_state_o
);

    // synchronised write protect pin
    logic write_protect_sync;
    logic hw_write_enable_flag;

    // bus state
    logic ack;
    logic next_ack;
    logic [31:0] rd_data;
    logic [31:0] next_rd_data;
    logic bus_req;
    logic wr_take;
    logic lane0;
    logic [`FPEC_ADR_BITS-1:0] adr;
    logic [7:0] wd;

    // control registers
    logic soft_write_enable;
    logic erase_setup_bit;
    logic program_setup_bit;
    logic erase_verify_bit;
    logic program_verify_bit;
    logic erase_run;
    logic program_run;
    logic [`FPEC_BLOCK_BITS-1:0] erase_block_select;
    logic ram_overlay_select;
    logic [`FPEC_RAM_AREA_MSB:0] ram_area;
    logic error_protect_flag;

    logic next_soft_write_enable;
    logic next_erase_setup_bit;
    logic next_program_setup_bit;
    logic next_erase_verify_bit;
    logic next_program_verify_bit;
    logic next_erase_run;
    logic next_program_run;
    logic [`FPEC_BLOCK_BITS-1:0] next_erase_block_select;
    logic next_ram_overlay_select;
    logic [`FPEC_RAM_AREA_MSB:0] next_ram_area;
    logic next_error_protect_flag;

    // derived state
    fpec_state_type flash_state;
    fpec_state_type next_flash_state;

    // register views
    logic [7:0] mode_control_view;
    logic [7:0] error_status_view;
    logic [`FPEC_BLOCK_BITS-1:0] block_candidate;
    logic write_gate;

    // pin crosses into ref_clk_i first; reset value reads as protected
    fpec_sync #(
        .RESET_VALUE(`FPEC_RST_PIN)
    ) u_wp_sync (
        .clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(write_protect_pin_i),
        .sync_o(write_protect_sync)
    );

    assign hw_write_enable_flag = ~write_protect_sync;

    // bus decode
    assign bus_req = wb_cyc_i & wb_stb_i;
    // a request still held in its ack cycle must not be taken a second time
    assign wr_take = bus_req & wb_we_i & ~ack;
    assign lane0 = wb_sel_i[0];
    assign adr = wb_adr_i[`FPEC_ADR_BITS-1:0];
    assign wd = wb_dat_i[7:0];

    // the gate uses the stored soft enable so that one write cannot both open and use it
    assign write_gate = hw_write_enable_flag & soft_write_enable & wd[`FPEC_BIT_SOFT_WRITE_ENABLE];

    always_comb begin
        mode_control_view = 8'h00;
        mode_control_view[`FPEC_BIT_HW_WRITE_ENABLE] = hw_write_enable_flag;
        mode_control_view[`FPEC_BIT_SOFT_WRITE_ENABLE] = soft_write_enable;
        mode_control_view[`FPEC_BIT_ERASE_SETUP] = erase_setup_bit;
        mode_control_view[`FPEC_BIT_PROGRAM_SETUP] = program_setup_bit;
        mode_control_view[`FPEC_BIT_ERASE_VERIFY] = erase_verify_bit;
        mode_control_view[`FPEC_BIT_PROGRAM_VERIFY] = program_verify_bit;
        mode_control_view[`FPEC_BIT_ERASE_RUN] = erase_run;
        mode_control_view[`FPEC_BIT_PROGRAM_RUN] = program_run;
        error_status_view = 8'h00;
        error_status_view[`FPEC_BIT_ERROR_PROTECT] = error_protect_flag;
    end

    // bus answer: ack one cycle after the request, dropped the cycle after
    always_comb begin
        next_ack = bus_req & ~ack;
        next_rd_data = 32'h0000_0000;
        if (bus_req & ~ack & ~wb_we_i) begin
            unique case (adr)
                `FPEC_OFS_MODE_CONTROL: begin
                    next_rd_data = {24'h00_0000, mode_control_view};
                end
                `FPEC_OFS_ERROR_STATUS: begin
                    next_rd_data = {24'h00_0000, error_status_view};
                end
                `FPEC_OFS_BLOCK_LOW: begin
                    next_rd_data = {24'h00_0000,
                        erase_block_select[`FPEC_BLOCK_LOW_BITS-1:0]};
                end
                `FPEC_OFS_BLOCK_HIGH: begin
                    next_rd_data = {28'h000_0000,
                        erase_block_select[`FPEC_BLOCK_BITS-1:`FPEC_BLOCK_LOW_BITS]};
                end
                `FPEC_OFS_RAM_OVERLAY: begin
                    next_rd_data = {28'h000_0000, ram_overlay_select, ram_area};
                end
                default: begin
                    // unmapped words answer with zero
                    next_rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack <= 1'b0;
            rd_data <= 32'h0000_0000;
        end else begin
            ack <= next_ack;
            rd_data <= next_rd_data;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rd_data;

    // control registers
    always_comb begin
        next_soft_write_enable = soft_write_enable;
        next_erase_setup_bit = erase_setup_bit;
        next_program_setup_bit = program_setup_bit;
        next_erase_verify_bit = erase_verify_bit;
        next_program_verify_bit = program_verify_bit;
        next_erase_run = erase_run;
        next_program_run = program_run;
        next_erase_block_select = erase_block_select;
        next_ram_overlay_select = ram_overlay_select;
        next_ram_area = ram_area;
        next_error_protect_flag = error_protect_flag;
        block_candidate = erase_block_select;

        if (wr_take & lane0 & (adr == `FPEC_OFS_MODE_CONTROL)) begin
            next_soft_write_enable = wd[`FPEC_BIT_SOFT_WRITE_ENABLE] &
                hw_write_enable_flag;
            next_erase_setup_bit = wd[`FPEC_BIT_ERASE_SETUP] & write_gate;
            next_program_setup_bit = wd[`FPEC_BIT_PROGRAM_SETUP] & write_gate;
            next_erase_verify_bit = wd[`FPEC_BIT_ERASE_VERIFY] & write_gate;
            next_program_verify_bit = wd[`FPEC_BIT_PROGRAM_VERIFY] & write_gate;
            // run needs the setup already standing and kept by this write
            next_erase_run = wd[`FPEC_BIT_ERASE_RUN] & write_gate & erase_setup_bit &
                wd[`FPEC_BIT_ERASE_SETUP];
            next_program_run = wd[`FPEC_BIT_PROGRAM_RUN] & write_gate & program_setup_bit &
                wd[`FPEC_BIT_PROGRAM_SETUP];
        end

        if (wr_take & lane0 & (adr == `FPEC_OFS_BLOCK_LOW)) begin
            block_candidate[`FPEC_BLOCK_LOW_BITS-1:0] = wd;
        end
        if (wr_take & lane0 & (adr == `FPEC_OFS_BLOCK_HIGH)) begin
            block_candidate[`FPEC_BLOCK_BITS-1:`FPEC_BLOCK_LOW_BITS] =
                wd[`FPEC_BLOCK_HIGH_BITS-1:0];
        end
        // two chosen blocks are never kept: the array erases one block at a time
        if ((block_candidate & (block_candidate - 12'h001)) != 12'h000) begin
            next_erase_block_select = `FPEC_RST_BLOCKS;
        end else begin
            next_erase_block_select = block_candidate;
        end

        // the overlay register is not gated by soft enable
        if (wr_take & lane0 & (adr == `FPEC_OFS_RAM_OVERLAY)) begin
            next_ram_overlay_select = wd[`FPEC_BIT_RAM_SELECT];
            next_ram_area = wd[`FPEC_RAM_AREA_MSB:0];
        end

        // setting the flag wins over every clearing term below
        // no software clear: once set, only reset drops the flag
        if (error_event_i & (erase_run | program_run)) begin
            next_error_protect_flag = 1'b1;
        end

        // overlay or error protection stops any running operation
        if (next_ram_overlay_select | next_error_protect_flag) begin
            next_erase_run = 1'b0;
            next_program_run = 1'b0;
        end

        // a cancelled setup drags its run bit down with it
        if (!next_erase_setup_bit) begin
            next_erase_run = 1'b0;
        end
        if (!next_program_setup_bit) begin
            next_program_run = 1'b0;
        end

        // pin high or soft enable low clears the rest, blocks included
        if (!hw_write_enable_flag) begin
            next_soft_write_enable = 1'b0;
        end
        if (!next_soft_write_enable) begin
            next_erase_setup_bit = 1'b0;
            next_program_setup_bit = 1'b0;
            next_erase_verify_bit = 1'b0;
            next_program_verify_bit = 1'b0;
            next_erase_run = 1'b0;
            next_program_run = 1'b0;
            next_erase_block_select = `FPEC_RST_BLOCKS;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_write_enable <= 1'b0;
            erase_setup_bit <= 1'b0;
            program_setup_bit <= 1'b0;
            erase_verify_bit <= 1'b0;
            program_verify_bit <= 1'b0;
            erase_run <= 1'b0;
            program_run <= 1'b0;
            erase_block_select <= `FPEC_RST_BLOCKS;
            ram_overlay_select <= 1'b0;
            ram_area <= 3'h0;
            error_protect_flag <= 1'b0;
        end else begin
            soft_write_enable <= next_soft_write_enable;
            erase_setup_bit <= next_erase_setup_bit;
            program_setup_bit <= next_program_setup_bit;
            erase_verify_bit <= next_erase_verify_bit;
            program_verify_bit <= next_program_verify_bit;
            erase_run <= next_erase_run;
            program_run <= next_program_run;
            erase_block_select <= next_erase_block_select;
            ram_overlay_select <= next_ram_overlay_select;
            ram_area <= next_ram_area;
            error_protect_flag <= next_error_protect_flag;
        end
    end

    // summary state for the array; run outranks verify, verify outranks setup
    // locked outranks all, so no working state shows while writes are shut off
    always_comb begin
        next_flash_state = FPEC_IDLE;
        if (!next_soft_write_enable | next_error_protect_flag) begin
            next_flash_state = FPEC_LOCKED;
        end else if (next_program_run) begin
            next_flash_state = FPEC_PROGRAM;
        end else if (next_erase_run) begin
            next_flash_state = FPEC_ERASE;
        end else if (next_program_verify_bit) begin
            next_flash_state = FPEC_PROG_VERIFY;
        end else if (next_erase_verify_bit) begin
            next_flash_state = FPEC_ERASE_VERIFY;
        end else if (next_program_setup_bit) begin
            next_flash_state = FPEC_PROG_SETUP;
        end else if (next_erase_setup_bit) begin
            next_flash_state = FPEC_ERASE_SETUP;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flash_state <= FPEC_LOCKED;
        end else begin
            flash_state <= next_flash_state;
        end
    end

    // array controls straight from the registers
    assign erase_setup_o = erase_setup_bit;
    assign program_setup_o = program_setup_bit;
    assign erase_verify_o = erase_verify_bit;
    assign program_verify_o = program_verify_bit;
    assign erase_run_o = erase_run;
    assign program_run_o = program_run;
    assign erase_block_o = erase_block_select;
    assign ram_overlay_select_o = ram_overlay_select;
    assign ram_area_o = ram_area;
    assign error_protect_flag_o = error_protect_flag;
    assign flash_state_o = flash_state;

endmodule

// file: dv/fpec_properties.sv
// port-level checks of the flash program/erase control
// assumes it is bound to fpec_top on one clock with an active-low async reset
`include "fpec_defs.svh"
module fpec_properties (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pin and detector
    input wire logic write_protect_pin_i,
    input wire logic error_event_i,
    // flash array controls
    input wire logic erase_setup_o,
    input wire logic program_setup_o,
    input wire logic erase_verify_o,
    input wire logic program_verify_o,
    input wire logic erase_run_o,
    input wire logic program_run_o,
    input wire logic [`FPEC_BLOCK_BITS-1:0] erase_block_o,
    input wire logic ram_overlay_select_o,
    input wire logic error_protect_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pin_steady;
    logic [2:0] next_pin_steady;
    logic pin_last;
    logic taken;
    logic mode_wr;

    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign mode_wr = taken && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == 8'h00 && wb_dat_i[6];

    // the pin crosses two flops, so its flag is judged only once it has settled
    always_comb begin
        next_pin_steady = pin_steady + 3'h1;
        if (write_protect_pin_i != pin_last)
            next_pin_steady = 3'h0;
        else if (pin_steady == 3'h7)
            next_pin_steady = pin_steady;
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_steady <= 3'h0;
            pin_last <= 1'b1;
        end else begin
            pin_steady <= next_pin_steady;
            pin_last <= write_protect_pin_i;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence status_rd_s;
        taken && !wb_we_i && wb_adr_i[7:0] == 8'h04;
    endsequence
    sequence err_run_s;
        error_event_i && (erase_run_o || program_run_o);
    endsequence

    status_read_a: assert property (status_rd_s |=>
        wb_dat_o == {24'h0, $past(error_protect_flag_o), 7'h00}) else $error("status read");
    hw_flag_a: assert property (taken && !wb_we_i && wb_adr_i[7:0] == 8'h00
        && pin_steady > 3'h4 |=> wb_dat_o[7] == !$past(write_protect_pin_i)
        && !($past(write_protect_pin_i) && wb_dat_o[6])) else $error("hw flag read");
    erase_setup_a: assert property ($rose(erase_setup_o) |->
        $past(mode_wr && wb_dat_i[5])) else $error("erase setup cause");
    prog_setup_a: assert property ($rose(program_setup_o) |->
        $past(mode_wr && wb_dat_i[4])) else $error("program setup cause");
    verify_set_a: assert property (($rose(erase_verify_o) |-> $past(mode_wr && wb_dat_i[3]))
        and ($rose(program_verify_o) |-> $past(mode_wr && wb_dat_i[2])))
        else $error("verify cause");
    erase_run_a: assert property ($rose(erase_run_o) |-> erase_setup_o &&
        $past(erase_setup_o) && $past(mode_wr && wb_dat_i[1])) else $error("erase run cause");
    prog_run_a: assert property ($rose(program_run_o) |-> program_setup_o &&
        $past(program_setup_o) && $past(mode_wr && wb_dat_i[0])) else $error("program run cause");
    setup_clear_a: assert property ((!erase_setup_o -> !erase_run_o) &&
        (!program_setup_o -> !program_run_o)) else $error("run without setup");
    overlay_lock_a: assert property (ram_overlay_select_o && $past(ram_overlay_select_o)
        |-> !erase_run_o && !program_run_o) else $error("run under overlay");
    block_onehot_a: assert property ($onehot0(erase_block_o)) else $error("two blocks");
    error_stop_a: assert property (err_run_s |=>
        error_protect_flag_o && !erase_run_o && !program_run_o) else $error("error not taken");
    flag_cause_a: assert property ($rose(error_protect_flag_o) |->
        $past(error_event_i && (erase_run_o || program_run_o))) else $error("flag cause");
endmodule

bind fpec_top fpec_properties u_fpec_props (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .write_protect_pin_i(write_protect_pin_i),
    .error_event_i(error_event_i), .erase_setup_o(erase_setup_o),
    .program_setup_o(program_setup_o), .erase_verify_o(erase_verify_o),
    .program_verify_o(program_verify_o), .erase_run_o(erase_run_o),
    .program_run_o(program_run_o), .erase_block_o(erase_block_o),
    .ram_overlay_select_o(ram_overlay_select_o), .error_protect_flag_o(error_protect_flag_o)
);

// file: dv/fpec_top_tb.sv
// self-checking bench of the flash program/erase control against a register model
// assumes fpec_top with the checker bound to it
`include "fpec_defs.svh"
module fpec_top_tb
    import fpec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, resetn_i, cyc, stb, we, pin, err, ack, es, ps, ev, pv, er, pr, ros, flag;
    logic [31:0] adr, dat, rdat, q;
    logic [3:0] sel, m_ram;
    logic [11:0] blk, m_blk;
    logic [2:0] area;
    logic [5:0] m_mode;
    logic m_hw, m_soft, m_flag;
    fpec_state_type st;
    int n_errors, check_count, seed;
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

    fpec_top dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .write_protect_pin_i(pin), .error_event_i(err), .erase_setup_o(es),
        .program_setup_o(ps), .erase_verify_o(ev), .program_verify_o(pv), .erase_run_o(er),
        .program_run_o(pr), .erase_block_o(blk), .ram_overlay_select_o(ros),
        .ram_area_o(area), .error_protect_flag_o(flag), .flash_state_o(st));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic stop_test();
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value register read expected %h seen %h", e, g);
        end
    endtask

    task automatic check_pins();
        logic [25:0] e, g;
        fpec_state_type s;
        s = FPEC_IDLE;
        if (!m_soft || m_flag)
            s = FPEC_LOCKED;
        else if (m_mode[0])
            s = FPEC_PROGRAM;
        else if (m_mode[1])
            s = FPEC_ERASE;
        else if (m_mode[2])
            s = FPEC_PROG_VERIFY;
        else if (m_mode[3])
            s = FPEC_ERASE_VERIFY;
        else if (m_mode[4])
            s = FPEC_PROG_SETUP;
        else if (m_mode[5])
            s = FPEC_ERASE_SETUP;
        e = {m_flag, m_ram, m_blk, m_mode, s};
        g = {flag, ros, area, blk, es, ps, ev, pv, er, pr, st};
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value control outputs expected %h seen %h", e, g);
        end
    endtask

    // the master never assumes a latency: it waits for ack, the watchdog ends a hang
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        dat <= d;
        sel <= s;
        do begin
            @(posedge ref_clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
        logic en;
        bus(a, 1'b1, d, s);
        en = m_soft & d[6] & m_hw;
        if (s[0]) begin
            case (a)
                8'h00: begin
                    m_mode = {en & d[5], en & d[4], en & d[3], en & d[2],
                        en & m_mode[5] & d[5] & d[1], en & m_mode[4] & d[4] & d[0]};
                    m_soft = d[6] & m_hw;
                end
                8'h08: m_blk[7:0] = m_soft ? d[7:0] : 8'h00;
                8'h0c: m_blk[11:8] = m_soft ? d[3:0] : 4'h0;
                8'h10: m_ram = d[3:0];
                default: ;
            endcase
        end
        if (!m_soft || $countones(m_blk) > 1)
            m_blk = 12'h000;
        if (m_ram[3] || m_flag)
            m_mode[1:0] = 2'b00;
        check_pins();
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        case (a)
            8'h00: e = {24'h0, m_hw, m_soft, m_mode};
            8'h04: e = {24'h0, m_flag, 7'h00};
            8'h08: e = {24'h0, m_blk[7:0]};
            8'h0c: e = {28'h0, m_blk[11:8]};
            8'h10: e = {28'h0, m_ram};
            default: e = 32'h0;
        endcase
        bus(a, 1'b0, 32'h0, 4'hf);
        check_reg(e, q);
    endtask

    task automatic set_pin(input logic v);
        @(posedge ref_clk_i);
        pin <= v;
        repeat (6) @(posedge ref_clk_i);
        m_hw = !v;
        if (v) begin
            m_soft = 1'b0;
            m_mode = 6'h00;
            m_blk = 12'h000;
        end
    endtask

    task automatic err_pulse();
        @(posedge ref_clk_i);
        err <= 1'b1;
        @(posedge ref_clk_i);
        err <= 1'b0;
        if (m_mode[1:0] != 2'b00) begin
            m_flag = 1'b1;
            m_mode[1:0] = 2'b00;
        end
        @(posedge ref_clk_i);
        check_pins();
    endtask

    task automatic do_reset();
        resetn_i <= 1'b0;
        {m_soft, m_flag, m_mode, m_blk, m_ram} = '0;
        m_hw = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
    endtask

    initial begin
        {resetn_i, cyc, stb, we, pin, err, adr, dat, sel} = '0;
        n_errors = 0;
        check_count = 0;
        seed = 65;
        do_reset();
        foreach (ofs[i]) rd(ofs[i]);
        wr(8'h00, 32'h3f);
        wr(8'h08, 32'h01);
        wr(8'h00, 32'h40);
        for (int b = 2; b < 6; b++) begin
            wr(8'h00, 32'h40 | (32'h1 << b));
            wr(8'h00, 32'h40);
        end
        wr(8'h00, 32'h62);
        wr(8'h00, 32'h62);
        wr(8'h00, 32'h40);
        wr(8'h00, 32'h51);
        wr(8'h00, 32'h51);
        wr(8'h00, 32'h50);
        wr(8'h08, 32'h01);
        wr(8'h0c, 32'h02);
        wr(8'h00, 32'h60);
        wr(8'h10, 32'h08);
        wr(8'h00, 32'h62);
        repeat (80) begin
            wr(ofs[$unsigned($random(seed)) % 6], $random(seed) | 32'h40, 4'($random(seed)));
            rd(ofs[$unsigned($random(seed)) % 6]);
        end
        wr(8'h10, 32'h00);
        wr(8'h00, 32'h40);
        wr(8'h08, 32'h04);
        set_pin(1'b1);
        rd(8'h00);
        rd(8'h08);
        wr(8'h00, 32'h40);
        set_pin(1'b0);
        rd(8'h00);
        err_pulse();
        wr(8'h00, 32'h40);
        wr(8'h00, 32'h60);
        wr(8'h00, 32'h62);
        err_pulse();
        rd(8'h04);
        do_reset();
        rd(8'h04);
        stop_test();
    end

    // the sequence needs well under a thousand cycles; ten thousand means a hang
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule
